/* shared/burst_sram_map.vh */
// Constants for the burst SRAM cycle decoder: widths, codes and sleep timing.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef BURST_SRAM_MAP_VH
`define BURST_SRAM_MAP_VH

`define ADDR_W          16
`define LANES           4
`define LANE_W          9
`define DATA_W          36
`define FIFO_DEPTH      16
`define FIFO_AW         4
`define BURST_CNT_W     2
`define SLEEP_CYCLES    2
`define CYC_IDLE        3'h0
`define CYC_DESELECT    3'h1
`define CYC_SLEEP       3'h2
`define CYC_READ        3'h3
`define CYC_WRITE       3'h4

`endif

/* hw/lane_fifo.v */
// Small synchronous FIFO with valid/ready handshakes on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module lane_fifo #(
   parameter WIDTH = 40,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire             clk,
   input  wire             rst_n,
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0]      wr_ptr_r;
   reg [AW:0]      rd_ptr_r;
   wire            full;
   wire            empty;
   wire            push;
   wire            pop;

   assign full      = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                      (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
   assign empty     = (wr_ptr_r == rd_ptr_r);
   assign in_ready  = !full;
   assign out_valid = !empty;
   assign push      = in_valid && !full;
   assign pop       = out_ready && !empty;
   assign out_data  = mem[rd_ptr_r[AW-1:0]];

   always @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_r[AW-1:0]] <= in_data;
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         wr_ptr_r <= {(AW+1){1'b0}};
         rd_ptr_r <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
      end
   end
endmodule // lane_fifo
`default_nettype wire

/* hw/burst_sram_decode.v */
// Cycle decoder of a flow-through burst SRAM: cycle type, burst address,
// write lanes and data-pin control. Write commands leave through a FIFO.
// Assumes bus inputs come from the same-clock controller; sleep and the
// output enable are asynchronous pins and are synchronised here.
`timescale 1ns/10ps
`default_nettype none
`include "burst_sram_map.vh"

module burst_sram_decode (
   input  wire                   CORE_CLK,
   input  wire                   NRST,
   input  wire [`ADDR_W-1:0]     ADDR,
   input  wire                   SEL_PRIMARY_N,
   input  wire                   SEL_DEPTH_HI,
   input  wire                   SEL_DEPTH_LO_N,
   input  wire                   PROC_ADDR_STROBE_N,
   input  wire                   CTRL_ADDR_STROBE_N,
   input  wire                   BURST_STEP_N,
   input  wire                   ALL_LANE_WR_N,
   input  wire                   BYTE_WR_GATE_N,
   input  wire [`LANES-1:0]      LANE_WR_SEL_N,
   input  wire                   BURST_ORDER,
   input  wire                   SLEEP_REQUEST,
   input  wire                   OUT_EN_N,
   input  wire [`DATA_W-1:0]     DQ_IN,
   output reg  [`DATA_W-1:0]     DQ_OE,
   output reg  [2:0]             CYCLE_TYPE,
   output reg  [`ADDR_W-1:0]     CORE_ADDR,
   output reg  [`LANES-1:0]      LANE_WR_EN,
   output reg                    ASLEEP,
   output reg                    WR_VALID,
   output reg  [`ADDR_W+`DATA_W+`LANES-1:0] WR_DATA,
   input  wire                   WR_READY
);
   // ---------------------------------------------------------------
   // Input registers and synchronisers
   // ---------------------------------------------------------------
   reg [`ADDR_W-1:0]  addr_r;
   reg                sel1_n_r;
   reg                sel2_r;
   reg                sel3_n_r;
   reg                psn_r;
   reg                csn_r;
   reg                step_n_r;
   reg                gw_n_r;
   reg                bg_n_r;
   reg [`LANES-1:0]   lane_n_r;
   reg                mode_r;
   reg [`DATA_W-1:0]  dq_r;
   reg                sleep_s1_r;
   reg                sleep_s2_r;
   reg                oe_s1_r;
   reg                oe_s2_r;

   always @(posedge CORE_CLK) begin
      addr_r     <= ADDR;
      sel1_n_r   <= SEL_PRIMARY_N;
      sel2_r     <= SEL_DEPTH_HI;
      sel3_n_r   <= SEL_DEPTH_LO_N;
      psn_r      <= PROC_ADDR_STROBE_N;
      csn_r      <= CTRL_ADDR_STROBE_N;
      step_n_r   <= BURST_STEP_N;
      gw_n_r     <= ALL_LANE_WR_N;
      bg_n_r     <= BYTE_WR_GATE_N;
      lane_n_r   <= LANE_WR_SEL_N;
      mode_r     <= BURST_ORDER;
      dq_r       <= DQ_IN;
      sleep_s1_r <= SLEEP_REQUEST;
      sleep_s2_r <= sleep_s1_r;
      oe_s1_r    <= OUT_EN_N;
      oe_s2_r    <= oe_s1_r;
   end

   // ---------------------------------------------------------------
   // Cycle decode
   // ---------------------------------------------------------------
   wire              wr_ind;
   wire [`LANES-1:0] lanes;
   wire              en_ok;
   wire              proc_start;
   wire              ctrl_start;
   wire              strobe_cycle;

   assign wr_ind = !gw_n_r || (!bg_n_r && !(&lane_n_r));
   assign lanes  = !gw_n_r ? {`LANES{1'b1}} :
                   (!bg_n_r ? ~lane_n_r : {`LANES{1'b0}});
   assign en_ok  = !sel1_n_r && sel2_r && !sel3_n_r;
   // The processor strobe is ignored while the primary enable is high.
   assign proc_start   = !psn_r && !sel1_n_r;
   // A controller strobe counts whenever the processor strobe is idle or ignored,
   // so a high primary enable under it still ends in a deselect.
   assign ctrl_start   = (psn_r || sel1_n_r) && !csn_r;
   assign strobe_cycle = proc_start || ctrl_start;

   reg                 sleep_r;
   reg [1:0]           sleep_cnt_r;
   reg                 burst_live_r;
   reg [`BURST_CNT_W-1:0] base_r;
   reg [`BURST_CNT_W-1:0] cnt_r;
   reg [`ADDR_W-1:0]   hi_addr_r;
   reg [2:0]           cyc_nxt;
   reg                 load_nxt;
   reg                 step_nxt;
   reg                 do_write;
   wire [`BURST_CNT_W-1:0] cnt_step;
   wire [`BURST_CNT_W-1:0] lo_addr;

   assign cnt_step = cnt_r + 2'h1;
   assign lo_addr  = mode_r ? (base_r ^ cnt_r) : (base_r + cnt_r);

   always @* begin
      cyc_nxt  = `CYC_IDLE;
      load_nxt = 1'b0;
      step_nxt = 1'b0;
      do_write = 1'b0;
      if (sleep_r) begin
         cyc_nxt = `CYC_SLEEP;
      end else if (strobe_cycle) begin
         if (!en_ok) begin
            cyc_nxt = `CYC_DESELECT;
         end else if (proc_start) begin
            cyc_nxt  = `CYC_READ;
            load_nxt = 1'b1;
         end else begin
            cyc_nxt  = wr_ind ? `CYC_WRITE : `CYC_READ;
            load_nxt = 1'b1;
            do_write = wr_ind;
         end
      end else if (burst_live_r) begin
         step_nxt = !step_n_r;
         cyc_nxt  = wr_ind ? `CYC_WRITE : `CYC_READ;
         do_write = wr_ind;
      end
   end

   // ---------------------------------------------------------------
   // State, burst counter and sleep sequencing
   // ---------------------------------------------------------------
   wire stall;
   wire fifo_in_ready;
   wire [`ADDR_W-1:0] full_addr;

   // A write that finds the FIFO full is dropped rather than stalling the bus:
   // the SRAM protocol has no wait state to offer.
   assign stall     = do_write && !fifo_in_ready;
   assign full_addr = load_nxt ? addr_r :
                      {hi_addr_r[`ADDR_W-1:2], step_nxt ?
                      (mode_r ? (base_r ^ cnt_step) : (base_r + cnt_step)) : lo_addr};

   always @(posedge CORE_CLK) begin
      if (!NRST) begin
         sleep_r      <= 1'b0;
         sleep_cnt_r  <= 2'h0;
         burst_live_r <= 1'b0;
         base_r       <= 2'h0;
         cnt_r        <= 2'h0;
         hi_addr_r    <= {`ADDR_W{1'b0}};
      end else begin
         if (sleep_s2_r != sleep_r) begin
            if (sleep_cnt_r == `SLEEP_CYCLES - 1) begin
               sleep_r     <= sleep_s2_r;
               sleep_cnt_r <= 2'h0;
            end else begin
               sleep_cnt_r <= sleep_cnt_r + 2'h1;
            end
         end else begin
            sleep_cnt_r <= 2'h0;
         end
         if (sleep_r || cyc_nxt == `CYC_DESELECT) begin
            burst_live_r <= 1'b0;
         end else if (load_nxt) begin
            burst_live_r <= 1'b1;
            base_r       <= addr_r[1:0];
            cnt_r        <= 2'h0;
            hi_addr_r    <= addr_r;
         end else if (step_nxt) begin
            cnt_r <= cnt_step;
         end
      end
   end

   // ---------------------------------------------------------------
   // Outputs and data-pin control
   // ---------------------------------------------------------------
   always @(posedge CORE_CLK) begin
      if (!NRST) begin
         CYCLE_TYPE <= `CYC_IDLE;
         CORE_ADDR  <= {`ADDR_W{1'b0}};
         LANE_WR_EN <= {`LANES{1'b0}};
         ASLEEP     <= 1'b0;
         DQ_OE      <= {`DATA_W{1'b0}};
      end else begin
         CYCLE_TYPE <= cyc_nxt;
         CORE_ADDR  <= full_addr;
         LANE_WR_EN <= (do_write && !stall) ? lanes : {`LANES{1'b0}};
         ASLEEP     <= sleep_r;
         // Output enable is masked in writes, deselect and sleep.
         DQ_OE <= {`DATA_W{(cyc_nxt == `CYC_READ) && !oe_s2_r}};
      end
   end

   wire                                   fifo_out_valid;
   wire [`ADDR_W+`DATA_W+`LANES-1:0]      fifo_out_data;
   wire                                   fifo_pop;

   assign fifo_pop = !WR_VALID || WR_READY;

   always @(posedge CORE_CLK) begin
      if (!NRST) begin
         WR_VALID <= 1'b0;
         WR_DATA  <= {(`ADDR_W+`DATA_W+`LANES){1'b0}};
      end else if (fifo_pop) begin
         WR_VALID <= fifo_out_valid;
         WR_DATA  <= fifo_out_data;
      end
   end

   lane_fifo #(
      .WIDTH (`ADDR_W+`DATA_W+`LANES),
      .DEPTH (`FIFO_DEPTH),
      .AW    (`FIFO_AW)
   ) u_wr_fifo (
      .clk       (CORE_CLK),
      .rst_n     (NRST),
      .in_valid  (do_write),
      .in_ready  (fifo_in_ready),
      .in_data   ({full_addr, dq_r, lanes}),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_out_data)
   );
endmodule // burst_sram_decode
`default_nettype wire

/* testbench/burst_sram_decode_sva.sv */
// Port checker for the burst SRAM cycle decoder.
// Assumes the map header and a bind onto every decoder instance.
`timescale 1ns/10ps
`default_nettype none
`include "burst_sram_map.vh"
module burst_sram_decode_chk (
   input wire logic        CORE_CLK,
   input wire logic        NRST,
   input wire logic [15:0] ADDR,
   input wire logic        SEL_PRIMARY_N,
   input wire logic        SEL_DEPTH_HI,
   input wire logic        SEL_DEPTH_LO_N,
   input wire logic        PROC_ADDR_STROBE_N,
   input wire logic        CTRL_ADDR_STROBE_N,
   input wire logic        ALL_LANE_WR_N,
   input wire logic        BYTE_WR_GATE_N,
   input wire logic [3:0]  LANE_WR_SEL_N,
   input wire logic        SLEEP_REQUEST,
   input wire logic [35:0] DQ_OE,
   input wire logic [2:0]  CYCLE_TYPE,
   input wire logic [15:0] CORE_ADDR,
   input wire logic [3:0]  LANE_WR_EN,
   input wire logic        ASLEEP
);
   default clocking dc @(posedge CORE_CLK);
   endclocking
   default disable iff (!NRST);
   wire logic awake = !SLEEP_REQUEST && !ASLEEP;
   wire logic sel_ok = !SEL_PRIMARY_N && SEL_DEPTH_HI && !SEL_DEPTH_LO_N;
   wire logic wr_ind = !ALL_LANE_WR_N || (!BYTE_WR_GATE_N && LANE_WR_SEL_N != 4'hf);
   a_ctrl_write: assert property (
      awake && sel_ok && PROC_ADDR_STROBE_N && !CTRL_ADDR_STROBE_N && wr_ind
      |-> ##2 CYCLE_TYPE == `CYC_WRITE && CORE_ADDR == $past(ADDR, 2))
      else $error("controller write start not decoded");
   a_proc_read: assert property (
      awake && sel_ok && !PROC_ADDR_STROBE_N
      |-> ##2 CYCLE_TYPE == `CYC_READ && CORE_ADDR == $past(ADDR, 2))
      else $error("processor start not a read");
   a_read_no_lanes: assert property (
      awake && sel_ok && PROC_ADDR_STROBE_N && !CTRL_ADDR_STROBE_N && !wr_ind
      |-> ##2 CYCLE_TYPE == `CYC_READ && LANE_WR_EN == 4'h0)
      else $error("read start wrote lanes");
   a_depth_desel: assert property (
      awake && !CTRL_ADDR_STROBE_N && !SEL_DEPTH_HI |-> ##2 CYCLE_TYPE == `CYC_DESELECT)
      else $error("depth select off did not deselect");
   a_primary_off: assert property (
      awake && !CTRL_ADDR_STROBE_N && SEL_PRIMARY_N |-> ##2 CYCLE_TYPE == `CYC_DESELECT)
      else $error("primary select off did not deselect");
   a_write_floats: assert property (
      CYCLE_TYPE == `CYC_WRITE |-> DQ_OE == 36'h0)
      else $error("pins driven in a write");
   a_drive_read: assert property (
      DQ_OE != 36'h0 |-> CYCLE_TYPE == `CYC_READ)
      else $error("pins driven outside a read");
   a_sleep_quiet: assert property (
      ASLEEP |-> DQ_OE == 36'h0 && LANE_WR_EN == 4'h0)
      else $error("activity during sleep");
   a_lane_map: assert property (
      LANE_WR_EN != 4'h0 |-> CYCLE_TYPE == `CYC_WRITE && LANE_WR_EN ==
      ($past(ALL_LANE_WR_N, 2) ? ~$past(LANE_WR_SEL_N, 2) : 4'hf))
      else $error("write lanes do not match write inputs");
   c_write: cover property (CYCLE_TYPE == `CYC_WRITE);
   c_sleep: cover property (ASLEEP);
   c_drive: cover property (DQ_OE != 36'h0);
endmodule // burst_sram_decode_chk
bind burst_sram_decode burst_sram_decode_chk u_chk (.*);
`default_nettype wire

/* testbench/wr_sink.sv */
// Consumer at the far end of the write queue.
// Assumes the bench sets stall; while stalled ready stays low.
`timescale 1ns/10ps
`default_nettype none
module wr_sink (
   input  wire logic        clk,
   input  wire logic        stall,
   input  wire logic        valid,
   input  wire logic [55:0] data,
   output wire logic        ready,
   output var  int          count,
   output var  logic [55:0] first
);
   assign ready = !stall;
   initial count = 0;
   always @(posedge clk) begin
      if (valid && ready) begin
         if (count == 0)
            first <= data;
         count <= count + 1;
      end
   end
endmodule // wr_sink
`default_nettype wire

/* testbench/burst_sram_decode_bench.sv */
// Self-checking bench for the burst SRAM cycle decoder.
// Assumes the map header, the design files and the write sink.
`timescale 1ns/10ps
`default_nettype none
`include "burst_sram_map.vh"
module burst_sram_decode_bench;
   logic        clk = 0, nrst = 0, ord = 0, slp = 0, oe = 1, stall = 0;
   logic [11:0] pins = 12'h5ff;
   logic [15:0] a = 16'h0;
   logic [35:0] dq = 36'h9abcdef01;
   wire  [35:0] dq_oe;
   wire  [15:0] ca;
   wire  [2:0]  cyc_t;
   wire  [3:0]  lw;
   wire  [55:0] wd;
   wire         asl, wv, wr;
   logic [55:0] first;
   int          fails = 0, cmp_count = 0, got;
   always #2.5 clk = ~clk;
   burst_sram_decode u_dut (.CORE_CLK(clk), .NRST(nrst), .ADDR(a), .SEL_PRIMARY_N(pins[11]),
      .SEL_DEPTH_HI(pins[10]), .SEL_DEPTH_LO_N(pins[9]), .PROC_ADDR_STROBE_N(pins[8]),
      .CTRL_ADDR_STROBE_N(pins[7]), .BURST_STEP_N(pins[6]), .ALL_LANE_WR_N(pins[5]),
      .BYTE_WR_GATE_N(pins[4]), .LANE_WR_SEL_N(pins[3:0]), .BURST_ORDER(ord),
      .SLEEP_REQUEST(slp), .OUT_EN_N(oe), .DQ_IN(dq), .DQ_OE(dq_oe), .CYCLE_TYPE(cyc_t),
      .CORE_ADDR(ca), .LANE_WR_EN(lw), .ASLEEP(asl), .WR_VALID(wv), .WR_DATA(wd),
      .WR_READY(wr));
   wr_sink u_sink (.clk(clk), .stall(stall), .valid(wv), .data(wd), .ready(wr),
      .count(got), .first(first));
   task automatic chk(input logic [55:0] g, input logic [55:0] e);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // One cycle of pins, then idle; the decode shows two edges later.
   task automatic cyc(input logic [11:0] v, input logic [15:0] adr);
      @(posedge clk);
      pins <= v;
      a <= adr;
      @(posedge clk);
      pins <= 12'h5ff;
      @(posedge clk);
      #1;
   endtask
   task automatic t_start;
      cyc(12'h55f, 16'h1234);
      chk(cyc_t, `CYC_WRITE);
      chk(ca, 16'h1234);
      chk(lw, 4'hf);
      chk(dq_oe, 36'h0);
      cyc(12'h4df, 16'h0040);
      chk(cyc_t, `CYC_READ);
      chk(lw, 4'h0);
   endtask
   task automatic t_lanes;
      for (int m = 0; m < 16; m++) begin
         cyc({8'h56, ~m[3:0]}, 16'h0100);
         chk(cyc_t, m ? `CYC_WRITE : `CYC_READ);
         chk(lw, m[3:0]);
      end
   endtask
   task automatic t_desel;
      logic [11:0] dv [4] = '{12'h0df, 12'hd7f, 12'h6df, 12'hc7f};
      for (int i = 0; i < 4; i++) begin
         cyc(dv[i], 16'h0);
         chk(cyc_t, `CYC_DESELECT);
      end
   endtask
   task automatic t_burst(input logic o, input logic [1:0] s);
      logic [1:0] e;
      @(posedge clk);
      ord <= o;
      oe <= 0;
      cyc(12'h4df, {14'h0, s});
      chk(ca, {14'h0, s});
      for (int i = 1; i < 5; i++) begin
         e = o ? s ^ i[1:0] : s + i[1:0];
         cyc(12'h5bf, 16'hffff);
         chk(ca, {14'h0, e});
         chk(cyc_t, `CYC_READ);
         chk(dq_oe, {36{1'b1}});
      end
      repeat (3) @(posedge clk);
      oe <= 1;
      repeat (5) @(posedge clk);
      #1;
      chk(ca, {14'h0, e});
      chk(dq_oe, 36'h0);
   endtask
   task automatic t_fifo;
      int base;
      base = got;
      @(posedge clk);
      stall <= 1;
      cyc(12'h55f, 16'h0208);
      cyc(12'h59f, 16'h0);
      chk(ca, 16'h0209);
      chk(cyc_t, `CYC_WRITE);
      cyc(12'h5df, 16'h0);
      chk(ca, 16'h0209);
      chk(cyc_t, `CYC_WRITE);
      repeat (18) cyc(12'h5df, 16'h0);
      chk(lw, 4'h0);
      chk(wv, 1'b1);
      @(posedge clk);
      stall <= 0;
      repeat (60) @(posedge clk);
      #1;
      // The full queue holds its sixteen words plus the one standing at the output.
      chk(got - base, `FIFO_DEPTH + 1);
      chk(wv, 1'b0);
      chk(first, {16'h1234, 36'h9abcdef01, 4'hf});
   endtask
   task automatic t_sleep;
      cyc(12'h0df, 16'h0);
      @(posedge clk);
      slp <= 1;
      repeat (8) @(posedge clk);
      #1;
      chk(asl, 1'b1);
      chk(cyc_t, `CYC_SLEEP);
      cyc(12'h55f, 16'h0300);
      chk(lw, 4'h0);
      @(posedge clk);
      slp <= 0;
      pins <= 12'haff;
      repeat (8) @(posedge clk);
      #1;
      chk(asl, 1'b0);
      chk(cyc_t, `CYC_IDLE);
   endtask
   task automatic give_verdict;
      $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk);
      nrst <= 1;
      repeat (3) @(posedge clk);
      t_start;
      t_lanes;
      t_desel;
      t_burst(0, 2'h1);
      t_burst(1, 2'h1);
      t_burst(1, 2'h2);
      t_fifo;
      t_sleep;
      give_verdict;
   end
   initial begin
      #100000;
      fails++;
      give_verdict;
   end
endmodule // burst_sram_decode_bench
`default_nettype wire
